// ===== tpm_pkg.sv
// tpm_pkg: constants for the four-link T1/J1 performance monitor
// assumes: register indices map to APB byte addresses as four times the index
package tpm_pkg;

	// ---------------------------------------------------------------
	// link and counter geometry
	// ---------------------------------------------------------------
	localparam int NUM_LINKS   = 4;
	localparam int NUM_CNT     = 7;
	localparam int CNT_W       = 16;
	localparam int SNAP_BYTES  = 12;
	localparam int IND_IDX_W   = 4;

	// counter slots, also the overflow flag bit of each
	localparam int C_CRC   = 0;
	localparam int C_DDS   = 1;
	localparam int C_PAT   = 2;
	localparam int C_SYNC  = 3;
	localparam int C_ALIGN = 4;
	localparam int C_FRM   = 5;
	localparam int C_LCV   = 6;

	// saturation value of each counter, by slot
	localparam logic [15:0] CNT_MAX [NUM_CNT] = '{16'h03FF, 16'h03FF, 16'hFFFF, 16'h001F,
		16'h0007, 16'h0FFF, 16'hFFFF};

	// indirect holding register indices
	localparam logic [3:0] IND_CRC_LO   = 4'h0;
	localparam logic [3:0] IND_CRC_HI   = 4'h1;
	localparam logic [3:0] IND_FRM_LO   = 4'h2;
	localparam logic [3:0] IND_FRM_HI   = 4'h3;
	localparam logic [3:0] IND_ALIGN    = 4'h4;
	localparam logic [3:0] IND_SYNC     = 4'h5;
	localparam logic [3:0] IND_PAT_LO   = 4'h6;
	localparam logic [3:0] IND_PAT_HI   = 4'h7;
	localparam logic [3:0] IND_LCV_LO   = 4'h8;
	localparam logic [3:0] IND_LCV_HI   = 4'h9;
	localparam logic [3:0] IND_DDS_LO   = 4'hA;
	localparam logic [3:0] IND_DDS_HI   = 4'hB;

	// ---------------------------------------------------------------
	// direct register indices (byte address is four times these)
	// ---------------------------------------------------------------
	localparam logic [9:0] REG_ACCESS_PORT = 10'h00E;
	localparam logic [9:0] REG_ACCESS_DATA = 10'h00F;
	localparam logic [7:0] REG_UPD_CTRL    = 8'hC2;
	localparam logic [7:0] REG_OVF_EN0     = 8'hC3;
	localparam logic [7:0] REG_OVF_EN1     = 8'hC4;
	localparam logic [7:0] REG_OVF_FLG0    = 8'hC5;
	localparam logic [7:0] REG_OVF_FLG1    = 8'hC6;
	localparam int          ADDR_W          = 12;

	// field positions
	localparam int PORT_IDX_LSB   = 0;
	localparam int PORT_LINK_LSB  = 4;
	localparam logic [7:0] PORT_MASK = 8'h3F;
	localparam int CTRL_AUTO      = 0;
	localparam int CTRL_MANUAL    = 1;
	localparam int CTRL_FMT_LSB   = 2;
	localparam int CTRL_B8ZS      = 4;
	localparam logic [7:0] CTRL_MASK = 8'h1F;
	localparam logic [7:0] FLG0_MASK = 8'h3F;
	localparam logic [7:0] FLG1_MASK = 8'h01;

	// framing formats as held in the control register
	typedef enum logic [1:0] {
		FMT_SF,
		FMT_ESF,
		FMT_DIGITAL_DATA,
		FMT_SLC96
	} tpm_fmt_t;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam longint SECOND_NS    = 64'd1000000000;
	localparam longint CLK_PERIOD_NS = 64'd40;
	localparam int     SECOND_CYC   = int'(SECOND_NS / CLK_PERIOD_NS);

endpackage

// ===== tpm_hold_mem.sv
// tpm_hold_mem: indirect holding registers, one snapshot of twelve bytes per link
// assumes: one clock, synchronous active-low reset, write enables per link
`timescale 1ns/1ps
`default_nettype none
module tpm_hold_mem
	import tpm_pkg::*;
#(
	parameter int LINKS = NUM_LINKS
) (
	input  wire logic                        clk_i,
	input  wire logic                        reset_n_i,
	input  wire logic                        ce_i,
	input  wire logic [LINKS-1:0]            wr_en_i,
	input  wire logic [SNAP_BYTES*8-1:0]     wr_data_i [LINKS],
	input  wire logic [1:0]                  rd_link_i,
	input  wire logic [IND_IDX_W-1:0]        rd_idx_i,
	output logic      [7:0]                  rd_data_o
);

	logic [SNAP_BYTES*8-1:0] store_ff [LINKS];
	logic [7:0]              rd_data_ff;

	// ---------------------------------------------------------------
	// snapshot store
	// ---------------------------------------------------------------
	// whole link written in one cycle so an update never tears a counter pair
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			for (int l = 0; l < LINKS; l++) begin
				store_ff[l] <= '0;
			end
		end else if (ce_i) begin
			for (int l = 0; l < LINKS; l++) begin
				if (wr_en_i[l]) begin
					store_ff[l] <= wr_data_i[l];
				end
			end
		end
	end

	// registered byte read, unused indices read as zero
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rd_data_ff <= 8'h00;
		end else if (ce_i) begin
			if (int'(rd_idx_i) < SNAP_BYTES) begin
				rd_data_ff <= store_ff[rd_link_i][rd_idx_i*8 +: 8];
			end else begin
				rd_data_ff <= 8'h00;
			end
		end
	end

	assign rd_data_o = rd_data_ff;

endmodule // tpm_hold_mem
`default_nettype wire

// ===== tpm_monitor.sv
// tpm_monitor: four-link T1/J1 performance monitor with APB register access
// assumes: event inputs are one-cycle pulses from framer logic on clk_i
`timescale 1ns/1ps
`default_nettype none
module tpm_monitor
	import tpm_pkg::*;
#(
	parameter int SECOND_CYCLES = SECOND_CYC
) (
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	input  wire logic                  ce_i,
	// apb slave
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [ADDR_W-1:0]     paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic      [31:0]           prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	// per-link event pulses
	input  wire logic [NUM_LINKS-1:0]  bipolar_viol_i,
	input  wire logic [NUM_LINKS-1:0]  b8zs_code_viol_i,
	input  wire logic [NUM_LINKS-1:0]  framing_bit_err_i,
	input  wire logic [NUM_LINKS-1:0]  crc6_err_i,
	input  wire logic [NUM_LINKS-1:0]  dds_pattern_err_i,
	input  wire logic [NUM_LINKS-1:0]  align_change_i,
	input  wire logic [NUM_LINKS-1:0]  sync_loss_i,
	input  wire logic [NUM_LINKS-1:0]  pattern_err_i,
	// overflow interrupt request
	output logic                       overflow_irq_o
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [7:0]             access_port_ff;
	logic [7:0]             ctrl_ff      [NUM_LINKS];
	logic [7:0]             ovf_en0_ff   [NUM_LINKS];
	logic [7:0]             ovf_en1_ff   [NUM_LINKS];
	logic [NUM_CNT-1:0]     ovf_flag_ff  [NUM_LINKS];
	logic [CNT_W-1:0]       cnt_ff       [NUM_LINKS][NUM_CNT];
	logic [31:0]            sec_cnt_ff;
	logic                   sec_tick_ff;
	logic [31:0]            prdata_ff;
	logic                   pready_ff;
	logic                   pslverr_ff;
	logic                   irq_ff;

	logic                   wr_acc;
	logic [9:0]             reg_idx;
	logic [1:0]             reg_page;
	logic [7:0]             reg_off;
	logic [NUM_LINKS-1:0]   update;
	logic [NUM_CNT-1:0]     event_vec    [NUM_LINKS];
	logic [NUM_CNT-1:0]     ovf_set      [NUM_LINKS];
	logic [CNT_W-1:0]       nxt_cnt      [NUM_LINKS][NUM_CNT];
	logic [SNAP_BYTES*8-1:0] snap        [NUM_LINKS];
	logic [7:0]             ind_byte;
	logic [NUM_CNT-1:0]     en_vec       [NUM_LINKS];
	logic [NUM_CNT-1:0]     ovf_clr      [NUM_LINKS];

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// one counter step: on transfer restart from the current event, else count and saturate
	function automatic logic [CNT_W:0] cnt_step(input logic [CNT_W-1:0] cur,
		input logic ev, input logic upd, input logic [CNT_W-1:0] maxv);
		logic [CNT_W:0] res;
		res = {1'b0, cur};
		if (upd) begin
			res = {1'b0, {(CNT_W-1){1'b0}}, ev};
		end else if (ev) begin
			if (cur == maxv) begin
				res = {1'b1, cur};
			end else begin
				res = {1'b0, cur + 16'h0001};
			end
		end
		return res;
	endfunction

	// read byte register data onto the 32-bit bus, upper bits zero
	function automatic logic [31:0] byte_word(input logic [7:0] b);
		return {24'h000000, b};
	endfunction

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	assign reg_idx  = paddr_i[ADDR_W-1:2];
	assign reg_page = reg_idx[9:8];   // link page for per-link registers
	assign reg_off  = reg_idx[7:0];
	assign wr_acc   = psel_i & penable_i & pready_ff & pwrite_i & ~pslverr_ff;

	// ---------------------------------------------------------------
	// one-second tick, shared by all links
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			sec_cnt_ff  <= 32'h00000000;
			sec_tick_ff <= 1'b0;
		end else if (ce_i) begin
			if (sec_cnt_ff == 32'(SECOND_CYCLES - 1)) begin
				sec_cnt_ff  <= 32'h00000000;
				sec_tick_ff <= 1'b1;
			end else begin
				sec_cnt_ff  <= sec_cnt_ff + 32'h00000001;
				sec_tick_ff <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// event selection and update triggers
	// ---------------------------------------------------------------
	// format gating lives here so the framer may report every event unconditionally
	always_comb begin
		for (int l = 0; l < NUM_LINKS; l++) begin
			event_vec[l]          = '0;
			event_vec[l][C_LCV]   = ctrl_ff[l][CTRL_B8ZS] ? b8zs_code_viol_i[l]
				: bipolar_viol_i[l];
			event_vec[l][C_FRM]   = framing_bit_err_i[l];
			event_vec[l][C_ALIGN] = align_change_i[l];
			event_vec[l][C_SYNC]  = sync_loss_i[l];
			event_vec[l][C_PAT]   = pattern_err_i[l];
			case (tpm_fmt_t'(ctrl_ff[l][CTRL_FMT_LSB +: 2]))
				FMT_ESF: begin
					event_vec[l][C_CRC] = crc6_err_i[l];
				end
				FMT_DIGITAL_DATA: begin
					event_vec[l][C_DDS] = dds_pattern_err_i[l];
				end
				FMT_SF, FMT_SLC96: begin
					event_vec[l][C_CRC] = 1'b0;
				end
				default: begin
					event_vec[l][C_CRC] = 1'b0;
				end
			endcase
			// manual trigger fires only on a 0-to-1 change of the stored bit
			update[l] = (sec_tick_ff & ctrl_ff[l][CTRL_AUTO])
				| (wr_acc && reg_page == l[1:0] && reg_off == REG_UPD_CTRL
				&& pwdata_i[CTRL_MANUAL] && !ctrl_ff[l][CTRL_MANUAL]);
		end
	end

	// next counter values and overflow events
	always_comb begin
		logic [CNT_W:0] step;
		step = '0;
		for (int l = 0; l < NUM_LINKS; l++) begin
			for (int c = 0; c < NUM_CNT; c++) begin
				step          = cnt_step(cnt_ff[l][c], event_vec[l][c], update[l], CNT_MAX[c]);
				nxt_cnt[l][c] = step[CNT_W-1:0];
				ovf_set[l][c] = step[CNT_W];
			end
		end
	end

	// snapshot layout of the holding registers
	always_comb begin
		for (int l = 0; l < NUM_LINKS; l++) begin
			snap[l] = '0;
			snap[l][IND_CRC_LO*8 +: 16]  = cnt_ff[l][C_CRC];
			snap[l][IND_FRM_LO*8 +: 16]  = cnt_ff[l][C_FRM];
			snap[l][IND_ALIGN*8 +: 8]    = cnt_ff[l][C_ALIGN][7:0];
			snap[l][IND_SYNC*8 +: 8]     = cnt_ff[l][C_SYNC][7:0];
			snap[l][IND_PAT_LO*8 +: 16]  = cnt_ff[l][C_PAT];
			snap[l][IND_LCV_LO*8 +: 16]  = cnt_ff[l][C_LCV];
			snap[l][IND_DDS_LO*8 +: 16]  = cnt_ff[l][C_DDS];
		end
	end

	// ---------------------------------------------------------------
	// counters
	// ---------------------------------------------------------------
	// counters saturate rather than wrap so a full interval never reads as small
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			for (int l = 0; l < NUM_LINKS; l++) begin
				for (int c = 0; c < NUM_CNT; c++) begin
					cnt_ff[l][c] <= '0;
				end
			end
		end else if (ce_i) begin
			for (int l = 0; l < NUM_LINKS; l++) begin
				for (int c = 0; c < NUM_CNT; c++) begin
					cnt_ff[l][c] <= nxt_cnt[l][c];
				end
			end
		end
	end

	// holding registers, written with the pre-clear counter values
	tpm_hold_mem #(
		.LINKS (NUM_LINKS)
	) u_hold (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.ce_i      (ce_i),
		.wr_en_i   (update),
		.wr_data_i (snap),
		.rd_link_i (access_port_ff[PORT_LINK_LSB +: 2]),
		.rd_idx_i  (access_port_ff[PORT_IDX_LSB +: IND_IDX_W]),
		.rd_data_o (ind_byte)
	);

	// ---------------------------------------------------------------
	// software registers
	// ---------------------------------------------------------------
	// access port is global, one for all links
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			access_port_ff <= 8'h00;
		end else if (ce_i) begin
			if (wr_acc && reg_idx == REG_ACCESS_PORT) begin
				access_port_ff <= pwdata_i[7:0] & PORT_MASK;
			end
		end
	end

	// per-link control and enable registers, one page per link
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			for (int l = 0; l < NUM_LINKS; l++) begin
				ctrl_ff[l]    <= 8'h00;
				ovf_en0_ff[l] <= 8'h00;
				ovf_en1_ff[l] <= 8'h00;
			end
		end else if (ce_i) begin
			for (int l = 0; l < NUM_LINKS; l++) begin
				if (wr_acc && reg_page == l[1:0]) begin
					if (reg_off == REG_UPD_CTRL) begin
						ctrl_ff[l] <= pwdata_i[7:0] & CTRL_MASK;
					end
					if (reg_off == REG_OVF_EN0) begin
						ovf_en0_ff[l] <= pwdata_i[7:0] & FLG0_MASK;
					end
					if (reg_off == REG_OVF_EN1) begin
						ovf_en1_ff[l] <= pwdata_i[7:0] & FLG1_MASK;
					end
				end
			end
		end
	end

	// write-one-to-clear masks, one per link page
	always_comb begin
		for (int l = 0; l < NUM_LINKS; l++) begin
			ovf_clr[l] = '0;
			if (wr_acc && reg_page == l[1:0] && reg_off == REG_OVF_FLG0) begin
				ovf_clr[l][C_FRM:C_CRC] = pwdata_i[C_FRM:C_CRC];
			end
			if (wr_acc && reg_page == l[1:0] && reg_off == REG_OVF_FLG1) begin
				ovf_clr[l][C_LCV] = pwdata_i[0];
			end
		end
	end

	// sticky overflow flags; a new overflow wins over the clear
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			for (int l = 0; l < NUM_LINKS; l++) begin
				ovf_flag_ff[l] <= '0;
			end
		end else if (ce_i) begin
			for (int l = 0; l < NUM_LINKS; l++) begin
				ovf_flag_ff[l] <= (ovf_flag_ff[l] & ~ovf_clr[l]) | ovf_set[l];
			end
		end
	end

	// interrupt request: any flag whose enable is set
	always_comb begin
		for (int l = 0; l < NUM_LINKS; l++) begin
			en_vec[l] = {ovf_en1_ff[l][0], ovf_en0_ff[l][C_FRM:C_CRC]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			irq_ff <= 1'b0;
		end else if (ce_i) begin
			irq_ff <= |((ovf_flag_ff[0] & en_vec[0]) | (ovf_flag_ff[1] & en_vec[1])
				| (ovf_flag_ff[2] & en_vec[2]) | (ovf_flag_ff[3] & en_vec[3]));
		end
	end

	// ---------------------------------------------------------------
	// apb answer: ready in the first access cycle, data latched at setup
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end else if (ce_i) begin
			pready_ff <= psel_i & ~penable_i;
			if (psel_i && !penable_i) begin
				pslverr_ff <= 1'b0;
				prdata_ff  <= 32'h00000000;
				if (reg_idx == REG_ACCESS_PORT) begin
					prdata_ff <= byte_word(access_port_ff);
				end else if (reg_idx == REG_ACCESS_DATA) begin
					prdata_ff <= byte_word(ind_byte);
				end else if (reg_off == REG_UPD_CTRL) begin
					prdata_ff <= byte_word(ctrl_ff[reg_page]);
				end else if (reg_off == REG_OVF_EN0) begin
					prdata_ff <= byte_word(ovf_en0_ff[reg_page]);
				end else if (reg_off == REG_OVF_EN1) begin
					prdata_ff <= byte_word(ovf_en1_ff[reg_page]);
				end else if (reg_off == REG_OVF_FLG0) begin
					prdata_ff <= byte_word({2'b00, ovf_flag_ff[reg_page][C_FRM:C_CRC]});
				end else if (reg_off == REG_OVF_FLG1) begin
					prdata_ff <= byte_word({7'h00, ovf_flag_ff[reg_page][C_LCV]});
				end else begin
					pslverr_ff <= 1'b1; // unmapped index
				end
			end
		end
	end

	assign prdata_o       = prdata_ff;
	assign pready_o       = pready_ff;
	assign pslverr_o      = pslverr_ff;
	assign overflow_irq_o = irq_ff;

endmodule // tpm_monitor
`default_nettype wire

// ===== tpm_monitor_props.sv
// tpm_monitor_props: port-level checks of the monitor's apb answer and overflow interrupt
// assumes: bound into tpm_monitor, single clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module tpm_monitor_props
	import tpm_pkg::*;
#(
	parameter int SECOND_CYCLES = SECOND_CYC
) (
	input wire logic                 clk_i,
	input wire logic                 reset_n_i,
	input wire logic                 psel_i,
	input wire logic                 penable_i,
	input wire logic                 pwrite_i,
	input wire logic [ADDR_W-1:0]    paddr_i,
	input wire logic [31:0]          prdata_o,
	input wire logic                 pready_o,
	input wire logic                 pslverr_o,
	input wire logic [NUM_LINKS-1:0] bipolar_viol_i,
	input wire logic [NUM_LINKS-1:0] b8zs_code_viol_i,
	input wire logic [NUM_LINKS-1:0] framing_bit_err_i,
	input wire logic [NUM_LINKS-1:0] crc6_err_i,
	input wire logic [NUM_LINKS-1:0] dds_pattern_err_i,
	input wire logic [NUM_LINKS-1:0] align_change_i,
	input wire logic [NUM_LINKS-1:0] sync_loss_i,
	input wire logic [NUM_LINKS-1:0] pattern_err_i,
	input wire logic                 overflow_irq_o
);
	// ---------------------------------------------------------------
	// helper terms
	// ---------------------------------------------------------------
	logic any_ev;
	logic apb_wr;
	// a rising interrupt edge needs an event or a register write one or two cycles earlier, a falling edge a write
	assign any_ev = |{bipolar_viol_i, b8zs_code_viol_i, framing_bit_err_i, crc6_err_i,
		dds_pattern_err_i, align_change_i, sync_loss_i, pattern_err_i};
	assign apb_wr = psel_i & penable_i & pwrite_i;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	chk_ready_single: assert property (pready_o |=> !pready_o)
		else $error("pready stayed high past one cycle");
	chk_ready_after_setup: assert property ((psel_i && !penable_i) |=> pready_o)
		else $error("no zero-wait answer after setup");
	chk_ready_in_access: assert property (pready_o |-> (psel_i && penable_i))
		else $error("pready outside an access phase");
	chk_rdata_upper_zero: assert property ((pready_o && !pwrite_i) |-> prdata_o[31:8] == 24'h000000)
		else $error("read data upper lanes not zero");
	chk_rdata_holds: assert property (!(psel_i && !penable_i) |=> $stable(prdata_o))
		else $error("read data moved outside a setup edge");
	chk_slverr_unmapped: assert property ((pready_o && paddr_i[11:2] == 10'h3FF) |->
		(pslverr_o && (pwrite_i || prdata_o == 32'h00000000)))
		else $error("unmapped index not refused");
	chk_slverr_mapped: assert property ((pready_o && paddr_i[11:2] == REG_ACCESS_PORT) |-> !pslverr_o)
		else $error("mapped index refused");
	chk_irq_rise_cause: assert property ($rose(overflow_irq_o) |->
		($past(any_ev, 1) || $past(any_ev, 2) || $past(apb_wr, 1) || $past(apb_wr, 2)))
		else $error("interrupt rose without event or write");
	chk_irq_fall_cause: assert property ($fell(overflow_irq_o) |-> ($past(apb_wr, 1) || $past(apb_wr, 2)))
		else $error("interrupt fell without a write");
endmodule // tpm_monitor_props

bind tpm_monitor tpm_monitor_props #(.SECOND_CYCLES(SECOND_CYCLES)) tpm_monitor_props_inst (
	.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o,
	.bipolar_viol_i, .b8zs_code_viol_i, .framing_bit_err_i, .crc6_err_i, .dds_pattern_err_i,
	.align_change_i, .sync_loss_i, .pattern_err_i, .overflow_irq_o
);
`default_nettype wire

// ===== tpm_monitor_tb_top.sv
// tpm_monitor_tb_top: directed self-checking bench for the four-link monitor
// assumes: zero-wait apb slave, one-second tick shortened to SEC cycles
`timescale 1ns/1ps
`default_nettype none
module tpm_monitor_tb_top
	import tpm_pkg::*;
;
	localparam int SEC = 50;
	logic        clk_i;
	logic        reset_n_i;
	logic        ce_i;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [3:0]  ev [8];
	logic [31:0] rdv;
	logic        err;
	int          mismatches;
	int          checks;

	// event slots: 0 bipolar, 1 b8zs, 2 framing, 3 crc, 4 dds, 5 align, 6 sync, 7 pattern
	tpm_monitor #(.SECOND_CYCLES(SEC)) tpm_monitor_inst (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .bipolar_viol_i(ev[0]), .b8zs_code_viol_i(ev[1]), .framing_bit_err_i(ev[2]),
		.crc6_err_i(ev[3]), .dds_pattern_err_i(ev[4]), .align_change_i(ev[5]), .sync_loss_i(ev[6]),
		.pattern_err_i(ev[7]), .overflow_irq_o(irq)
	);

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one transfer; the request stands until the rising edge at which pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n = 0;
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk_i);
		penable <= 1'b1;
		@(posedge clk_i);
		while (pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				mismatches++;
				$display("[FAIL] apb answer expected 1 seen timeout");
				summarize();
			end
			@(posedge clk_i);
		end
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// per-link page: 0 control, 1 enable0, 2 enable1, 3 flags0, 4 flags1
	function automatic logic [11:0] ctl(input int l, input int o);
		return 12'h308 + 12'(l * 1024) + 12'(o * 4);
	endfunction

	task automatic rd_ind(input logic [1:0] l, input logic [3:0] i, input logic [7:0] exp, input string nm);
		apb(1'b1, 12'h038, {2'b00, l, i});
		apb(1'b0, 12'h03C, 8'h00);
		check(nm, rdv, {24'h000000, exp});
	endtask

	// n back-to-back high cycles count n events
	task automatic pulse(input int k, input int l, input int n);
		@(posedge clk_i);
		ev[k][l] <= 1'b1;
		repeat (n) @(posedge clk_i);
		ev[k][l] <= 1'b0;
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic test_reset();
		for (int l = 0; l < 4; l++) begin
			for (int o = 0; o < 5; o++) begin
				apb(1'b0, ctl(l, o), 8'h00);
				check("reset value", rdv, 32'h00000000);
			end
		end
		apb(1'b1, ctl(2, 0), 8'hFC);
		apb(1'b0, ctl(2, 0), 8'h00);
		check("control mask", rdv, 32'h0000001C);
		apb(1'b1, 12'hFFC, 8'h55);
		check("unmapped write error", 32'(err), 32'h00000001);
		apb(1'b0, 12'hFFC, 8'h00);
		check("unmapped read error", 32'(err), 32'h00000001);
		$display("test reset done");
	endtask

	// esf, ami on link 1: crc counted, dds and b8zs ignored
	task automatic test_esf();
		logic [7:0] exp [12] = '{8'h04, 8'h00, 8'h05, 8'h00, 8'h01, 8'h02, 8'h06, 8'h00,
			8'h03, 8'h00, 8'h00, 8'h00};
		apb(1'b1, ctl(1, 0), 8'h04);
		pulse(0, 1, 3);
		pulse(1, 1, 2);
		pulse(2, 1, 5);
		pulse(3, 1, 4);
		pulse(4, 1, 2);
		pulse(5, 1, 1);
		pulse(6, 1, 2);
		pulse(7, 1, 6);
		apb(1'b1, ctl(1, 0), 8'h06);
		for (int i = 0; i < 12; i++) begin
			rd_ind(2'd1, 4'(i), exp[i], "esf snapshot");
		end
		rd_ind(2'd0, 4'h8, 8'h00, "other link");
		apb(1'b1, ctl(1, 0), 8'h04);
		apb(1'b1, ctl(1, 0), 8'h06);
		rd_ind(2'd1, 4'h8, 8'h00, "cleared line code");
		rd_ind(2'd1, 4'h6, 8'h00, "cleared pattern");
		$display("test esf done");
	endtask

	// digital data framing with b8zs on link 2: count past one byte
	task automatic test_dds();
		apb(1'b1, ctl(2, 0), 8'h18);
		pulse(1, 2, 300);
		pulse(0, 2, 1);
		pulse(4, 2, 3);
		pulse(3, 2, 2);
		apb(1'b1, ctl(2, 0), 8'h1A);
		rd_ind(2'd2, 4'h8, 8'h2C, "b8zs low");
		rd_ind(2'd2, 4'h9, 8'h01, "b8zs high");
		rd_ind(2'd2, 4'hA, 8'h03, "dds low");
		rd_ind(2'd2, 4'hB, 8'h00, "dds high");
		rd_ind(2'd2, 4'h0, 8'h00, "crc outside esf");
		$display("test dds done");
	endtask

	// slc-96 on link 3: alignment counter saturates and flags, interrupt gated by enable
	task automatic test_ovf();
		apb(1'b1, ctl(3, 0), 8'h0C);
		pulse(3, 3, 1);
		pulse(4, 3, 1);
		pulse(5, 3, 8);
		pulse(7, 3, 2);
		apb(1'b0, ctl(3, 3), 8'h00);
		check("align flag", rdv, 32'h00000010);
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		check("irq masked", 32'(irq), 32'h00000000);
		apb(1'b1, ctl(3, 1), 8'h10);
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		check("irq enabled", 32'(irq), 32'h00000001);
		apb(1'b1, ctl(3, 3), 8'h10);
		apb(1'b0, ctl(3, 3), 8'h00);
		check("flag cleared", rdv, 32'h00000000);
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		check("irq cleared", 32'(irq), 32'h00000000);
		apb(1'b1, ctl(3, 0), 8'h0E);
		rd_ind(2'd3, 4'h4, 8'h07, "align saturated");
		rd_ind(2'd3, 4'h0, 8'h00, "slc crc");
		rd_ind(2'd3, 4'hA, 8'h00, "slc dds");
		rd_ind(2'd3, 4'h6, 8'h02, "slc pattern");
		$display("test overflow done");
	endtask

	// link 0: snapshot stays without auto; with auto and a steady event each tick takes one full interval
	task automatic test_auto();
		pulse(7, 0, 5);
		apb(1'b1, ctl(0, 0), 8'h02);
		rd_ind(2'd0, 4'h6, 8'h05, "manual pattern");
		repeat (SEC + 10) @(posedge clk_i);
		rd_ind(2'd0, 4'h6, 8'h05, "no auto tick");
		apb(1'b1, ctl(0, 0), 8'h01);
		@(posedge clk_i);
		ev[7][0] <= 1'b1;
		repeat (2 * SEC + 10) @(posedge clk_i);
		rd_ind(2'd0, 4'h6, 8'(SEC), "auto full interval");
		rd_ind(2'd0, 4'h7, 8'h00, "auto interval high");
		ev[7][0] <= 1'b0;
		repeat (2 * SEC + 10) @(posedge clk_i);
		rd_ind(2'd0, 4'h6, 8'h00, "auto tick");
		$display("test auto done");
	endtask

	// link 0: events while the clock enable is low are not counted; a mid-run reset clears all
	task automatic test_freeze();
		apb(1'b1, ctl(0, 0), 8'h00);
		ce_i <= 1'b0;
		pulse(7, 0, 4);
		@(posedge clk_i);
		ce_i <= 1'b1;
		pulse(7, 0, 3);
		apb(1'b1, ctl(0, 0), 8'h02);
		rd_ind(2'd0, 4'h6, 8'h03, "frozen events");
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		rd_ind(2'd0, 4'h6, 8'h00, "reset snapshot");
		apb(1'b0, ctl(0, 0), 8'h00);
		check("reset control", rdv, 32'h00000000);
		$display("test freeze done");
	endtask

	// ---------------------------------------------------------------
	// clock and main sequence
	// ---------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	initial begin
		reset_n_i = 1'b0;
		ce_i = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		for (int k = 0; k < 8; k++) begin
			ev[k] = 4'h0;
		end
		mismatches = 0;
		checks = 0;
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		test_reset();
		test_esf();
		test_dds();
		test_ovf();
		test_auto();
		test_freeze();
		summarize();
	end
endmodule // tpm_monitor_tb_top
`default_nettype wire
